/* design/pst_init2_selftest.sv */
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "pst_cfg.svh"
// Behaviour
// RQ1 - phase two sends identification, not acceleration
// RQ2 - each frame carries eight data bits
// RQ3 - asynchronous mode repeats each value 16 times
// RQ4 - synchronous mode repeats each value 8 times
// RQ5 - protocol revision half-nibbles 01 then 00
// RQ6 - block count sent as 00,10,00,00
// RQ7 - maker code, then type 00,00,00,01
// RQ8 - axis nibble follows direction setting
// RQ9 - range nibble encodes full-scale variant
// RQ10 - self-test runs three consecutive sub-phases
// RQ11 - sub-phase one averages offset, stimulus off
// RQ12 - extended flag sends averaged raw offset
// RQ13 - freeze cancellation, stimulus on in two
// RQ14 - average second half of interval two
// RQ15 - extended flag sends averaged self-test value
// RQ16 - compare with limits, then stimulus off
// RQ17 - sub-phase three re-averages offset baseline
// RQ18 - pass leads to normal mode
// RQ19 - fail reruns up to repeat count
// RQ20 - zeros sent when values not ready
// RQ21 - one passing sequence stops repeats
// RQ22 - half-nibbles in ascending page order
module pst_init2_selftest #(
  parameter int unsigned ST1_LOG2 = 8,
  parameter int unsigned ST2_HALF_LOG2 = 7,
  parameter int unsigned ST3_LOG2 = 8,
  parameter int unsigned FREEZE_EXTRA_CYC =
    `T_FREEZE_EXTRA_US * `CLK_FREQ_MHZ
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic slot_tick,
  input wire logic sample_valid,
  input wire logic [9:0] sample_data,
  output pst_pkg::pst_msg_t tx_msg,
  output logic selftest_stim_en,
  output logic offset_freeze,
  output logic normal_mode,
  output logic selftest_defect,
  output logic [9:0] baseline_offset
);
  import pst_pkg::*;

  pst_state_t s_reg;
  pst_state_t s_next;
  logic start;
  logic [`P2_SEQ_W-1:0] seq;
  logic [9:0] off_tx;
  logic [9:0] st_tx;
  logic [3:0] axis_nib;
  logic [3:0] range_nib;
  logic [4:0] rep_k;
  logic [1:0] hn;
  logic [19:0] acc_sum;

  // ================================================================
  // Helpers
  function automatic logic smp_last(input logic [10:0] cnt,
                                    input int unsigned lg);
    return cnt == 11'((1 << lg) - 1);
  endfunction

  function automatic logic [9:0] avg_of(input logic [19:0] acc,
                                        input int unsigned lg);
    return 10'(acc >> lg);
  endfunction

  // ================================================================
  // Phase-two content
  always_comb begin
    rep_k = s_reg.cfg.sync_mode ? `REP_SYNC : `REP_ASYNC; // RQ3 RQ4
    axis_nib = {s_reg.cfg.dir, 2'h0}; // RQ8
    range_nib = `P2_RANGE_BASE + 4'(s_reg.cfg.range_sel); // RQ9
    // Withheld until the sub-phase has finished, or when not enabled
    off_tx = (s_reg.cfg.extended_phase2_enable && s_reg.off_ok) ?
             s_reg.off_avg : 10'h000; // RQ12 RQ20
    st_tx = (s_reg.cfg.extended_phase2_enable && s_reg.st_ok) ?
            s_reg.st_avg : 10'h000; // RQ15 RQ20
    // Ascending page, then half-nibble; trailing fields sent as zero
    seq = {`P2_PROTO_HN, `P2_BLOCKS_HN, s_reg.cfg.maker_code,
           `P2_TYPE_HN, axis_nib, range_nib,
           off_tx[3:0], off_tx[7:4], st_tx[1:0], off_tx[9:8],
           st_tx[5:2], st_tx[9:6], 16'h0000}; // RQ5 RQ6 RQ7 RQ22
    hn = 2'(seq >> (7'(`P2_SEQ_W - 2) - 7'({s_reg.val_idx, 1'b0})));
    acc_sum = s_reg.acc + 20'(sample_data);
    start = reg_wr && (reg_addr == `REG_CTRL) &&
            reg_wdata[`CTRL_START];
  end

  // ================================================================
  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.tx.valid = 1'b0;
    s_next.rdata = 32'h0000_0000;

    if (reg_wr) begin
      case (reg_addr)
        `REG_CTRL: begin
          s_next.cfg.sync_mode = reg_wdata[`CTRL_SYNC];
          s_next.cfg.extended_phase2_enable = reg_wdata[`CTRL_EXT];
          s_next.cfg.dir = reg_wdata[`CTRL_DIR_LSB +: 2];
          s_next.cfg.range_sel = reg_wdata[`CTRL_RNG_LSB +: 2];
          s_next.cfg.selftest_repeat_limit = reg_wdata[`CTRL_RPT_LSB +: 3];
        end
        `REG_MAKER: s_next.cfg.maker_code = reg_wdata[7:0];
        `REG_LIM_LO: s_next.cfg.lim_lo = reg_wdata[9:0];
        `REG_LIM_HI: s_next.cfg.lim_hi = reg_wdata[9:0];
        default: ;
      endcase
    end

    if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL: s_next.rdata = 32'({s_reg.cfg.selftest_repeat_limit,
          s_reg.cfg.range_sel, s_reg.cfg.dir,
          s_reg.cfg.extended_phase2_enable, s_reg.cfg.sync_mode, 1'b0});
        `REG_MAKER: s_next.rdata = 32'(s_reg.cfg.maker_code);
        `REG_LIM_LO: s_next.rdata = 32'(s_reg.cfg.lim_lo);
        `REG_LIM_HI: s_next.rdata = 32'(s_reg.cfg.lim_hi);
        `REG_STATUS: s_next.rdata = 32'({s_reg.stg, s_reg.fails,
          s_reg.defect, s_reg.normal, s_reg.stg != STG_IDLE &&
          s_reg.stg != STG_DONE, s_reg.p2_done, s_reg.p2_on});
        `REG_RESULT: s_next.rdata = 32'({s_reg.st_avg, 6'h00,
          s_reg.off_avg});
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end

    // Phase two: one half-nibble per slot, held for k slots
    if (s_reg.p2_on && slot_tick) begin
      s_next.tx.valid = 1'b1; // RQ1
      s_next.tx.data = {s_reg.val_idx, hn}; // RQ2
      if (s_reg.rep_cnt == rep_k - 5'd1) begin // RQ3 RQ4
        s_next.rep_cnt = 5'd0;
        if (s_reg.val_idx == `P2_VALUES - 6'd1) begin
          s_next.p2_on = 1'b0;
          s_next.p2_done = 1'b1;
        end else begin
          s_next.val_idx = s_reg.val_idx + 6'd1; // RQ22
        end
      end else begin
        s_next.rep_cnt = s_reg.rep_cnt + 5'd1;
      end
    end

    // Self-test sub-phases
    case (s_reg.stg)
      STG_OFFS: begin
        if (sample_valid) begin // RQ11
          s_next.acc = acc_sum;
          s_next.smp_cnt = s_reg.smp_cnt + 11'd1;
          if (smp_last(s_reg.smp_cnt, ST1_LOG2)) begin
            s_next.off_avg = avg_of(acc_sum, ST1_LOG2);
            s_next.off_ok = 1'b1;
            s_next.acc = 20'h00000;
            s_next.smp_cnt = 11'h000;
            s_next.oc_frz = 1'b1; // RQ13
            s_next.st_en = 1'b1; // RQ13
            s_next.stg = STG_DEFL_WAIT; // RQ10
          end
        end
      end
      STG_DEFL_WAIT: begin
        // First half lets the stimulated deflection settle
        if (sample_valid) begin
          s_next.smp_cnt = s_reg.smp_cnt + 11'd1;
          if (smp_last(s_reg.smp_cnt, ST2_HALF_LOG2)) begin
            s_next.smp_cnt = 11'h000;
            s_next.stg = STG_DEFL_AVG; // RQ14
          end
        end
      end
      STG_DEFL_AVG: begin
        if (sample_valid) begin // RQ14
          s_next.acc = acc_sum;
          s_next.smp_cnt = s_reg.smp_cnt + 11'd1;
          if (smp_last(s_reg.smp_cnt, ST2_HALF_LOG2)) begin
            s_next.st_avg = avg_of(acc_sum, ST2_HALF_LOG2);
            s_next.st_ok = 1'b1;
            s_next.acc = 20'h00000;
            s_next.smp_cnt = 11'h000;
            s_next.stg = STG_CHECK;
          end
        end
      end
      STG_CHECK: begin
        s_next.st_pass = (s_reg.st_avg >= s_reg.cfg.lim_lo) &&
                         (s_reg.st_avg <= s_reg.cfg.lim_hi); // RQ16
        s_next.st_en = 1'b0; // RQ16
        s_next.cyc_cnt = 20'h00000;
        s_next.stg = STG_HOLD;
      end
      STG_HOLD: begin
        // Cancellation stays frozen 2 ms past the deflection window
        s_next.cyc_cnt = s_reg.cyc_cnt + 20'd1;
        if (s_reg.cyc_cnt == 20'(FREEZE_EXTRA_CYC - 1)) begin // RQ13
          s_next.oc_frz = 1'b0;
          s_next.stg = STG_BASE;
        end
      end
      STG_BASE: begin
        if (sample_valid) begin // RQ17
          s_next.acc = acc_sum;
          s_next.smp_cnt = s_reg.smp_cnt + 11'd1;
          if (smp_last(s_reg.smp_cnt, ST3_LOG2)) begin
            s_next.base_avg = avg_of(acc_sum, ST3_LOG2);
            s_next.acc = 20'h00000;
            s_next.smp_cnt = 11'h000;
            if (s_reg.st_pass) begin
              s_next.normal = 1'b1; // RQ18 RQ21
              s_next.stg = STG_DONE;
            end else if (s_reg.fails <
                         s_reg.cfg.selftest_repeat_limit) begin
              s_next.fails = s_reg.fails + 3'd1; // RQ19
              s_next.stg = STG_OFFS;
            end else begin
              s_next.defect = 1'b1;
              s_next.stg = STG_DONE;
            end
          end
        end
      end
      STG_IDLE, STG_DONE: ;
      default: s_next.stg = STG_IDLE;
    endcase

    // Start restarts both sequences from a clean slate
    if (start) begin
      s_next.p2_on = 1'b1;
      s_next.p2_done = 1'b0;
      s_next.val_idx = 6'd0;
      s_next.rep_cnt = 5'd0;
      s_next.stg = STG_OFFS; // RQ10
      s_next.acc = 20'h00000;
      s_next.smp_cnt = 11'h000;
      s_next.fails = 3'd0;
      s_next.normal = 1'b0;
      s_next.defect = 1'b0;
      s_next.off_ok = 1'b0;
      s_next.st_ok = 1'b0;
      s_next.st_en = 1'b0;
      s_next.oc_frz = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.cfg.lim_hi <= `LIM_HI_RST;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign tx_msg = s_reg.tx;
  assign selftest_stim_en = s_reg.st_en;
  assign offset_freeze = s_reg.oc_frz;
  assign normal_mode = s_reg.normal;
  assign selftest_defect = s_reg.defect;
  assign baseline_offset = s_reg.base_avg;

  // ================================================================
  // Checks
  property p_proto;
    @(posedge sys_clk) disable iff (srst)
    tx_msg.valid && tx_msg.data[7:2] == 6'd0 |->
      tx_msg.data[1:0] == 2'h1 && $past(s_reg.p2_on);
  endproperty
  a_proto: assert property (p_proto) else $error("bad protocol"); // RQ5

  property p_blocks;
    @(posedge sys_clk) disable iff (srst)
    tx_msg.valid && tx_msg.data[7:2] == 6'd3 |-> tx_msg.data[1:0] == 2'h2;
  endproperty
  a_blocks: assert property (p_blocks) else $error("bad blocks"); // RQ6

  property p_type;
    @(posedge sys_clk) disable iff (srst)
    tx_msg.valid && tx_msg.data[7:2] == 6'd13 |->
      tx_msg.data[1:0] == 2'h1;
  endproperty
  a_type: assert property (p_type) else $error("bad type"); // RQ7

  property p_axis;
    @(posedge sys_clk) disable iff (srst)
    tx_msg.valid && tx_msg.data[7:2] == 6'd14 |->
      tx_msg.data[1:0] == $past(s_reg.cfg.dir);
  endproperty
  a_axis: assert property (p_axis) else $error("bad axis"); // RQ8

  property p_range;
    @(posedge sys_clk) disable iff (srst)
    tx_msg.valid && tx_msg.data[7:2] == 6'd16 |->
      tx_msg.data[1:0] ==
      ($past(s_reg.cfg.range_sel) == 2'h0 ? 2'h1 : 2'h2);
  endproperty
  a_range: assert property (p_range) else $error("bad range"); // RQ9

  property p_zero_ext;
    @(posedge sys_clk) disable iff (srst)
    tx_msg.valid && tx_msg.data[7:2] >= `P2_EXT_FIRST &&
      tx_msg.data[7:2] <= `P2_EXT_LAST &&
      !$past(s_reg.cfg.extended_phase2_enable) |->
      tx_msg.data[1:0] == 2'h0;
  endproperty
  a_zero_ext: assert property (p_zero_ext) else $error("ext leak"); // RQ20

  property p_defl;
    @(posedge sys_clk) disable iff (srst)
    s_reg.stg == STG_DEFL_WAIT || s_reg.stg == STG_DEFL_AVG |->
      selftest_stim_en && offset_freeze;
  endproperty
  a_defl: assert property (p_defl) else $error("stim not on"); // RQ13

  property p_check;
    @(posedge sys_clk) disable iff (srst)
    s_reg.stg == STG_CHECK && clk_en && !start |=>
      !selftest_stim_en && offset_freeze && s_reg.stg == STG_HOLD;
  endproperty
  a_check: assert property (p_check) else $error("check order"); // RQ16

  property p_pass;
    @(posedge sys_clk) disable iff (srst)
    $rose(normal_mode) |-> $past(s_reg.stg) == STG_BASE &&
      $past(s_reg.st_pass) && !selftest_defect;
  endproperty
  a_pass: assert property (p_pass) else $error("bad pass"); // RQ18

  property p_stay;
    @(posedge sys_clk) disable iff (srst)
    normal_mode && !start |=> normal_mode && s_reg.stg == STG_DONE;
  endproperty
  a_stay: assert property (p_stay) else $error("rerun after pass"); // RQ21

  property p_rep;
    @(posedge sys_clk) disable iff (srst)
    s_reg.p2_on |-> s_reg.rep_cnt < rep_k;
  endproperty
  a_rep: assert property (p_rep) else $error("repeat overrun"); // RQ3

  property p_retry;
    @(posedge sys_clk) disable iff (srst)
    $changed(s_reg.fails) && s_reg.fails != 3'd0 |->
      $past(s_reg.stg) == STG_BASE &&
      !$past(s_reg.st_pass) && s_reg.stg == STG_OFFS;
  endproperty
  a_retry: assert property (p_retry) else $error("bad retry"); // RQ19

  c_p2_done: cover property (@(posedge sys_clk) $rose(s_reg.p2_done));
  c_normal: cover property (@(posedge sys_clk) $rose(normal_mode));
  c_defect: cover property (@(posedge sys_clk) $rose(selftest_defect));
  c_retry: cover property (@(posedge sys_clk) $rose(s_reg.fails));

endmodule

/* design/pst_cfg.svh */
`ifndef PST_CFG_SVH
`define PST_CFG_SVH

// ==================================================================
// Register map and fields
`define REG_CTRL 8'h00
`define REG_MAKER 8'h04
`define REG_LIM_LO 8'h08
`define REG_LIM_HI 8'h0C
`define REG_STATUS 8'h10
`define REG_RESULT 8'h14
`define CTRL_START 0
`define CTRL_SYNC 1
`define CTRL_EXT 2
`define CTRL_DIR_LSB 3
`define CTRL_RNG_LSB 5
`define CTRL_RPT_LSB 7
`define RESULT_ST_LSB 16
`define LIM_HI_RST 10'h3FF

// ==================================================================
// Phase-two content
`define P2_PROTO_HN 4'h4
`define P2_BLOCKS_HN 8'h20
`define P2_TYPE_HN 8'h01
`define P2_RANGE_BASE 4'h7
`define P2_SEQ_W 72
`define P2_VALUES 6'd36
`define P2_EXT_FIRST 6'd18
`define P2_EXT_LAST 6'd27
`define REP_ASYNC 5'd16
`define REP_SYNC 5'd8

// ==================================================================
// Timing
`define CLK_FREQ_MHZ 250
`define T_FREEZE_EXTRA_US 2000

`endif

/* design/pst_pkg.sv */
package pst_pkg;

  typedef enum logic [3:0] {
    STG_IDLE = 4'h0,
    STG_OFFS = 4'h1,
    STG_DEFL_WAIT = 4'h2,
    STG_DEFL_AVG = 4'h3,
    STG_CHECK = 4'h4,
    STG_HOLD = 4'h5,
    STG_BASE = 4'h6,
    STG_DONE = 4'h7
  } pst_stage_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } pst_msg_t;

  typedef struct packed {
    logic sync_mode;
    logic extended_phase2_enable;
    logic [1:0] dir;
    logic [1:0] range_sel;
    logic [2:0] selftest_repeat_limit;
    logic [7:0] maker_code;
    logic [9:0] lim_lo;
    logic [9:0] lim_hi;
  } pst_cfg_t;

  typedef struct packed {
    pst_cfg_t cfg;
    logic p2_on;
    logic p2_done;
    logic [5:0] val_idx;
    logic [4:0] rep_cnt;
    pst_msg_t tx;
    pst_stage_t stg;
    logic [10:0] smp_cnt;
    logic [19:0] cyc_cnt;
    logic [19:0] acc;
    logic [9:0] off_avg;
    logic [9:0] st_avg;
    logic [9:0] base_avg;
    logic off_ok;
    logic st_ok;
    logic st_pass;
    logic [2:0] fails;
    logic normal;
    logic defect;
    logic st_en;
    logic oc_frz;
    logic [31:0] rdata;
  } pst_state_t;

endpackage

/* bench/pst_rx_model.sv */
`timescale 1ns/1ps
// Far side plus sensor front end: slot timing, samples, message tally
module pst_rx_model #(
  parameter int SLOT_CYC = 8,
  parameter int SMP_CYC = 4,
  parameter logic [9:0] OFF_V = 10'h123,
  parameter logic [9:0] ST_V = 10'h2C6
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic selftest_stim_en,
  input wire pst_pkg::pst_msg_t tx_msg,
  output logic slot_tick,
  output logic sample_valid,
  output logic [9:0] sample_data,
  output logic [15:0] msg_cnt
);
  import pst_pkg::*;
  logic [7:0] slot_reg;
  logic [7:0] smp_reg;
  // ==========================================================
  // Slot pulses, samples and received-message count
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      slot_reg <= 8'h00;
      smp_reg <= 8'h00;
      slot_tick <= 1'b0;
      sample_valid <= 1'b0;
      sample_data <= 10'h000;
      msg_cnt <= 16'h0000;
    end else begin
      slot_reg <= (slot_reg == 8'(SLOT_CYC - 1)) ? 8'h00 : slot_reg + 8'h01;
      slot_tick <= (slot_reg == 8'(SLOT_CYC - 1));
      smp_reg <= (smp_reg == 8'(SMP_CYC - 1)) ? 8'h00 : smp_reg + 8'h01;
      sample_valid <= (smp_reg == 8'(SMP_CYC - 1));
      // Stale data is inverted every cycle, so it equals the last sample on alternate cycles
      if (smp_reg == 8'(SMP_CYC - 1))
        sample_data <= selftest_stim_en ? ST_V : OFF_V;
      else
        sample_data <= ~sample_data;
      if (tx_msg.valid)
        msg_cnt <= msg_cnt + 16'h0001;
    end
  end
endmodule

/* bench/pst_init2_selftest_bench.sv */
`timescale 1ns/1ps
module pst_init2_selftest_bench;
  import pst_pkg::*;
  localparam logic [9:0] OFF_V = 10'h123;
  localparam logic [9:0] ST_V = 10'h2C6;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic slot_tick, sample_valid, selftest_stim_en, offset_freeze;
  logic [9:0] sample_data, baseline_offset;
  logic normal_mode, selftest_defect, stim_d;
  logic [15:0] msg_cnt;
  pst_msg_t tx_msg;
  int error_cnt = 0;
  int compares = 0;
  int stim_rises = 0;

  always #2 sys_clk = ~sys_clk;

  pst_init2_selftest #(.ST1_LOG2(2), .ST2_HALF_LOG2(2), .ST3_LOG2(2),
    .FREEZE_EXTRA_CYC(8)) pst_init2_selftest_i (.sys_clk(sys_clk),
    .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .slot_tick(slot_tick),
    .sample_valid(sample_valid), .sample_data(sample_data),
    .tx_msg(tx_msg), .selftest_stim_en(selftest_stim_en),
    .offset_freeze(offset_freeze), .normal_mode(normal_mode),
    .selftest_defect(selftest_defect), .baseline_offset(baseline_offset));

  pst_rx_model #(.OFF_V(OFF_V), .ST_V(ST_V)) pst_rx_model_i (
    .sys_clk(sys_clk), .srst(srst), .selftest_stim_en(selftest_stim_en),
    .tx_msg(tx_msg), .slot_tick(slot_tick), .sample_valid(sample_valid),
    .sample_data(sample_data), .msg_cnt(msg_cnt));

  // Counts self-test runs by stimulus switch-on
  always @(posedge sys_clk) begin
    stim_d <= selftest_stim_en;
    if (selftest_stim_en === 1'b1 && stim_d === 1'b0)
      stim_rises++;
  end

  // ==========================================================
  // Shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  function automatic logic [31:0] ctrl(input logic sy, input logic ex,
      input logic [1:0] dr, input logic [1:0] rg, input logic [2:0] rp);
    return {22'h0, rp, rg, dr, ex, sy, 1'b1};
  endfunction

  function automatic logic [1:0] exp_hn(input int i, input logic [7:0] mk,
      input logic [1:0] dr, input logic [1:0] rg, input logic [9:0] of,
      input logic [9:0] sv);
    logic [19:0] nb;
    logic [3:0] r;
    int j;
    nb = {sv[9:6], sv[5:2], sv[1:0], of[9:8], of[7:4], of[3:0]};
    r = 4'h7 + {2'h0, rg};
    j = i - 18;
    case (i)
      0: return 2'h1;
      3: return 2'h2;
      13: return 2'h1;
      14: return dr;
      16: return r[3:2];
      17: return r[1:0];
      default: ;
    endcase
    if (i >= 6 && i <= 9)
      return mk[(7 - 2 * (i - 6)) -: 2];
    if (i >= 18 && i <= 27)
      return nb[((j / 2) * 4 + ((j % 2 == 0) ? 2 : 0)) +: 2];
    return 2'h0;
  endfunction

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk({31'h0, tx_msg.valid}, 32'h0);
    chk({22'h0, baseline_offset, normal_mode, selftest_defect}, 32'h0);
    rd(8'h00, 32'h0);
    rd(8'h0C, 32'h3FF);
    wr(8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C, 32'h0);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, 32'h0);
    $display("test reset done");
  endtask

  task automatic run_stream(input logic sy, input logic ex,
      input logic [1:0] dr, input logic [1:0] rg, input logic [7:0] mk);
    int k;
    int w;
    logic [5:0] idx;
    logic [15:0] c0;
    k = sy ? 8 : 16;
    stim_rises = 0;
    wr(8'h04, {24'h0, mk});
    wr(8'h00, ctrl(sy, ex, dr, rg, 3'h0));
    c0 = msg_cnt;
    for (int m = 0; m < 36 * k; m++) begin
      idx = 6'(m / k);
      w = 0;
      do begin
        @(posedge sys_clk);
        #1;
        w++;
      end while (tx_msg.valid !== 1'b1 && w < 100);
      chk({31'h0, tx_msg.valid}, 32'h1);
      chk({24'h0, tx_msg.data}, {24'h0, idx, exp_hn(int'(idx), mk, dr, rg,
        ex ? OFF_V : 10'h000, ex ? ST_V : 10'h000)});
    end
    w = 0;
    repeat (40) begin
      @(posedge sys_clk);
      #1;
      if (tx_msg.valid === 1'b1)
        w++;
    end
    chk(w, 0);
    chk({16'h0, msg_cnt - c0}, 32'(36 * k));
    chk({31'h0, normal_mode}, 32'h1);
    chk({31'h0, selftest_defect}, 32'h0);
    chk({22'h0, baseline_offset}, {22'h0, OFF_V});
    chk(stim_rises, 1);
    chk({31'h0, selftest_stim_en}, 32'h0);
    chk({31'h0, offset_freeze}, 32'h0);
    rd(8'h14, {6'h0, ST_V, 6'h0, OFF_V});
    $display("test stream done");
  endtask

  task automatic t_fail();
    int w;
    stim_rises = 0;
    wr(8'h0C, 32'h100);
    wr(8'h00, ctrl(1'b1, 1'b0, 2'h0, 2'h0, 3'h2));
    w = 0;
    while (selftest_stim_en !== 1'b1 && w < 300) begin
      @(posedge sys_clk);
      #1;
      w++;
    end
    chk({31'h0, offset_freeze}, 32'h1);
    w = 0;
    while (selftest_stim_en === 1'b1 && w < 300) begin
      @(posedge sys_clk);
      #1;
      w++;
    end
    chk({31'h0, offset_freeze}, 32'h1);
    w = 0;
    while (selftest_defect !== 1'b1 && w < 3000) begin
      @(posedge sys_clk);
      #1;
      w++;
    end
    chk({31'h0, selftest_defect}, 32'h1);
    chk(stim_rises, 3);
    chk({31'h0, normal_mode}, 32'h0);
    // Frozen clock must swallow the write
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(8'h0C, 32'h3FF);
    clk_en <= 1'b1;
    rd(8'h0C, 32'h100);
    // Reset after the failed run clears the verdict
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk({30'h0, selftest_defect, tx_msg.valid}, 32'h0);
    rd(8'h0C, 32'h3FF);
    $display("test retry done");
  endtask

  // ==========================================================
  // Run control
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    error_cnt++;
    test_done();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    run_stream(1'b0, 1'b0, 2'h1, 2'h2, 8'hA5);
    run_stream(1'b1, 1'b1, 2'h2, 2'h3, 8'h3C);
    run_stream(1'b1, 1'b0, 2'h0, 2'h0, 8'h5A);
    run_stream(1'b1, 1'b1, 2'h3, 2'h1, 8'hC3);
    t_fail();
    test_done();
  end
endmodule
